// *** hdl/rcs_consts.svh ***
// Register indices, defaults, ranges and scale constants for the ramp/current selector
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
`define RCS_IX_RAMP 6'h00
`define RCS_IX_METH 6'h01
`define RCS_IX_OPMODE 6'h02
`define RCS_IX_VNOM 6'h03
`define RCS_IX_TU 6'h04
`define RCS_IX_RUN 6'h05
`define RCS_IX_STOP 6'h06
`define RCS_IX_ACC 6'h07
`define RCS_IX_DEC 6'h08
`define RCS_IX_LI 6'h09
`define RCS_IX_LF 6'h0A
`define RCS_IX_LG 6'h0B
`define RCS_IX_LSF 6'h0C
`define RCS_IX_VS 6'h0D
`define RCS_IX_VR 6'h0E
`define RCS_IX_TA 6'h0F
`define RCS_IX_TD 6'h10
`define RCS_IX_VERB 6'h11
`define RCS_IX_STAT 6'h12
`define RCS_VNOM_DEF 16'h5DC0
`define RCS_VNOM_MIN 32'h0000_2EE0
`define RCS_VNOM_MAX 32'h0000_BB80
`define RCS_TU_DEF 7'h32
`define RCS_PCT_MAX 32'h0000_0064
`define RCS_RUN_DEF 7'h64
`define RCS_STOP_DEF 7'h32
`define RCS_ACC_DEF 7'h64
`define RCS_ACC_MIN 7'h19
`define RCS_CUR_MAX 7'h64
`define RCS_LI_MAX 32'h0000_2EE0
`define RCS_F_MAX 32'h0000_00C8
`define RCS_LG_MIN 32'hFFFF_FF38
`define RCS_LG_MAX 32'h0000_00C8
`define RCS_VS_DEF 32'h0000_0064
`define RCS_VR_DEF 32'h0000_03E8
`define RCS_VCEIL 32'h000F_4240
`define RCS_T_MIN 32'h0000_0001
`define RCS_T_MAX 32'h0007_A120
`define RCS_T_DEF 32'h0000_01F4
`define RCS_RAMP_MAX 32'h0000_0001
`define RCS_METH_MAX 32'h0000_0002
`define RCS_VERB_MAX 32'h0000_0002
`define RCS_VERB_WARN 2'h2
`define RCS_VERB_DEF 2'h1
`define RCS_TOL_HI 20'h0000B
`define RCS_TOL_LO 20'h00009
`define RCS_TOL_SCALE 20'h0000A
`define RCS_PCT_SQ 32'h0000_2710
`define RCS_AVAIL_VSH 3
`define RCS_AVAIL_VELSH 6
`define RCS_INERT_SH 4
`define RCS_RESP_OKAY 2'h0
`define RCS_RESP_SLVERR 2'h2
`define RCS_RESP_DECERR 2'h3
`endif

// *** hdl/rcs_pkg.sv ***
// Types shared by the ramp/current selector
package rcs_pkg;
  typedef enum logic [1:0] {
    MS_STOP = 2'b00,
    MS_ACCEL = 2'b01,
    MS_CONST = 2'b10,
    MS_DECEL = 2'b11
  } rcs_motion_t;
  typedef enum logic [1:0] {
    CM_BASIC = 2'b00,
    CM_MANUAL = 2'b01,
    CM_AUTO = 2'b10
  } rcs_cmethod_t;
endpackage : rcs_pkg

// *** hdl/rcs_selector.sv ***
// Ramp profile and phase current selector with AXI4-Lite registers
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_selector (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [31:0] cmd_velocity,
  input wire logic [15:0] supply_mv,
  output logic [6:0] phase_current_pct,
  output logic [1:0] motion_state,
  output logic supply_warning,
  output logic clamp_warning,
  output logic [31:0] prof_start_velocity,
  output logic [31:0] prof_accel_time,
  output logic [31:0] prof_decel_time,
  output logic [15:0] auto_accel_rate
);
  logic ramp_profile_select_reg;
  rcs_pkg::rcs_cmethod_t current_method_select_reg;
  logic [1:0] op_mode_reg;
  logic [15:0] nominal_supply_voltage_reg;
  logic [6:0] torque_utilization_reg;
  logic [6:0] run_current_pct_reg, stop_current_pct_reg;
  logic [6:0] accel_current_pct_reg, decel_current_pct_reg;
  logic [13:0] load_inertia_reg;
  logic [7:0] load_friction_reg, static_load_friction_reg;
  logic signed [8:0] load_gravity_reg;
  logic [31:0] start_velocity_reg, running_velocity_reg;
  logic [31:0] accel_time_reg, decel_time_reg;
  logic [1:0] alarm_message_verbosity_reg;
  rcs_pkg::rcs_motion_t motion_state_reg, motion_next;
  logic [31:0] vprev_reg, vmag;
  logic aw_held_reg, w_held_reg, wr_go, wr_ok, wr_known, wr_do;
  logic [5:0] aw_idx_reg;
  logic [31:0] wd;
  logic [31:0] wdata_reg;
  logic [31:0] rmux;
  logic stop_trig_reg, motion_start, auto_on;
  rcs_pkg::rcs_cmethod_t eff_method;
  logic [15:0] sup_s1_reg, sup_s2_reg, sup_s3_reg, sup_q_reg;
  logic warn_next;
  logic [15:0] grav_mag, avail_run, avail_zero;
  logic [7:0] c_run, c_stop, c_acc, c_dec;

  function automatic logic [31:0] abs32(input logic signed [31:0] v);
    abs32 = v[31] ? 32'(-v) : 32'(v);
  endfunction : abs32

  function automatic logic [15:0] avail_tq(input logic [15:0] vn, input logic [31:0] vel);
    logic [15:0] t, s;
    t = vn >> `RCS_AVAIL_VSH;
    s = 16'(vel >> `RCS_AVAIL_VELSH);
    avail_tq = (t > s) ? 16'(t - s) : 16'h0001;
  endfunction : avail_tq

  // Result bit 7 flags a clamp; current = need / (available * utilization)
  function automatic logic [7:0] cur_pct(input logic [15:0] req, input logic [15:0] av,
                                         input logic [6:0] tu, input logic [6:0] lo);
    logic [31:0] den, q;
    den = 32'(av) * 32'(tu);
    q = (den == 32'h0) ? 32'hFFFF_FFFF : (32'(req) * `RCS_PCT_SQ) / den;
    if (q > `RCS_PCT_MAX)
      cur_pct = {1'b1, `RCS_CUR_MAX};
    else if (q < 32'(lo))
      cur_pct = {1'b1, lo};
    else
      cur_pct = {1'b0, q[6:0]};
  endfunction : cur_pct

  // Bus handshake: one write and one read in flight
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_do = wr_go && wr_ok;
  assign wd = wdata_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      wdata_reg <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RCS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
      end
      if (wr_go)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= !wr_known ? `RCS_RESP_DECERR :
                       (wr_ok ? `RCS_RESP_OKAY : `RCS_RESP_SLVERR);
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Range and access checks; a refused write leaves the setting untouched
  always_comb
  begin
    wr_ok = 1'b1;
    wr_known = 1'b1;
    case (aw_idx_reg)
      `RCS_IX_RAMP: wr_ok = (wd <= `RCS_RAMP_MAX) && (motion_state_reg == rcs_pkg::MS_STOP);
      `RCS_IX_METH: wr_ok = (wd <= `RCS_METH_MAX);
      `RCS_IX_OPMODE: wr_ok = 1'b1;
      `RCS_IX_VNOM: wr_ok = (wd >= `RCS_VNOM_MIN) && (wd <= `RCS_VNOM_MAX);
      `RCS_IX_TU: wr_ok = (wd <= `RCS_PCT_MAX);
      `RCS_IX_RUN, `RCS_IX_STOP:
        wr_ok = (current_method_select_reg != rcs_pkg::CM_AUTO) && (wd <= `RCS_PCT_MAX);
      `RCS_IX_ACC:
        wr_ok = (current_method_select_reg == rcs_pkg::CM_MANUAL) &&
                (wd >= 32'(`RCS_ACC_MIN)) && (wd <= `RCS_PCT_MAX);
      `RCS_IX_DEC, `RCS_IX_STAT: wr_ok = 1'b0;
      `RCS_IX_LI: wr_ok = (wd <= `RCS_LI_MAX);
      `RCS_IX_LF, `RCS_IX_LSF: wr_ok = (wd <= `RCS_F_MAX);
      `RCS_IX_LG: wr_ok = ($signed(wd) >= $signed(`RCS_LG_MIN)) &&
                          ($signed(wd) <= $signed(`RCS_LG_MAX));
      `RCS_IX_VS: wr_ok = (wd <= running_velocity_reg);
      `RCS_IX_VR: wr_ok = (wd >= `RCS_T_MIN) && (wd <= `RCS_VCEIL) &&
                          (wd >= start_velocity_reg);
      `RCS_IX_TA, `RCS_IX_TD: wr_ok = (wd >= `RCS_T_MIN) && (wd <= `RCS_T_MAX);
      `RCS_IX_VERB: wr_ok = (wd <= `RCS_VERB_MAX);
      default:
      begin
        wr_ok = 1'b0;
        wr_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ramp_profile_select_reg <= 1'b0;
      current_method_select_reg <= rcs_pkg::CM_BASIC;
      op_mode_reg <= 2'h0;
      nominal_supply_voltage_reg <= `RCS_VNOM_DEF;
      torque_utilization_reg <= `RCS_TU_DEF;
      load_inertia_reg <= 14'h0000;
      load_friction_reg <= 8'h00;
      static_load_friction_reg <= 8'h00;
      load_gravity_reg <= 9'h000;
      start_velocity_reg <= `RCS_VS_DEF;
      running_velocity_reg <= `RCS_VR_DEF;
      accel_time_reg <= `RCS_T_DEF;
      decel_time_reg <= `RCS_T_DEF;
      alarm_message_verbosity_reg <= `RCS_VERB_DEF;
    end
    else if (wr_do)
    begin
      case (aw_idx_reg)
        `RCS_IX_RAMP: ramp_profile_select_reg <= wd[0];
        `RCS_IX_METH: current_method_select_reg <= rcs_pkg::rcs_cmethod_t'(wd[1:0]);
        `RCS_IX_OPMODE: op_mode_reg <= wd[1:0];
        `RCS_IX_VNOM: nominal_supply_voltage_reg <= wd[15:0];
        `RCS_IX_TU: torque_utilization_reg <= wd[6:0];
        `RCS_IX_LI: load_inertia_reg <= wd[13:0];
        `RCS_IX_LF: load_friction_reg <= wd[7:0];
        `RCS_IX_LSF: static_load_friction_reg <= wd[7:0];
        `RCS_IX_LG: load_gravity_reg <= wd[8:0];
        `RCS_IX_VS: start_velocity_reg <= wd;
        `RCS_IX_VR: running_velocity_reg <= wd;
        `RCS_IX_TA: accel_time_reg <= wd;
        `RCS_IX_TD: decel_time_reg <= wd;
        `RCS_IX_VERB: alarm_message_verbosity_reg <= wd[1:0];
        default: ;
      endcase
    end
  end

  // method only honoured in internal profiling
  assign eff_method = (op_mode_reg != 2'h0) ? rcs_pkg::CM_BASIC : current_method_select_reg;
  assign auto_on = (eff_method == rcs_pkg::CM_AUTO);

  assign vmag = abs32(cmd_velocity);
  always_comb
  begin
    if (vmag == 32'h0)
      motion_next = rcs_pkg::MS_STOP;
    else if (vmag > vprev_reg)
      motion_next = rcs_pkg::MS_ACCEL;
    else if (vmag < vprev_reg)
      motion_next = rcs_pkg::MS_DECEL;
    else
      motion_next = rcs_pkg::MS_CONST;
  end
  assign motion_start = (motion_state_reg == rcs_pkg::MS_STOP) &&
                        (motion_next != rcs_pkg::MS_STOP);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      motion_state_reg <= rcs_pkg::MS_STOP;
      vprev_reg <= 32'h0;
    end
    else
    begin
      motion_state_reg <= motion_next;
      vprev_reg <= vmag;
    end
  end
  assign motion_state = motion_state_reg;

  // Automatic current computation from load and torque curve
  assign grav_mag = 16'(abs32(32'(load_gravity_reg)));
  assign avail_run = avail_tq(nominal_supply_voltage_reg, running_velocity_reg);
  assign avail_zero = avail_tq(nominal_supply_voltage_reg, 32'h0);
  assign c_stop = cur_pct(16'(grav_mag + 16'(static_load_friction_reg)), avail_zero,
                          torque_utilization_reg, 7'h00);
  assign c_run = cur_pct(16'(grav_mag + 16'(load_friction_reg)), avail_run,
                         torque_utilization_reg, 7'h00);
  assign c_acc = cur_pct(16'(grav_mag + 16'(load_friction_reg) +
                         16'(load_inertia_reg >> `RCS_INERT_SH)), avail_run,
                         torque_utilization_reg, `RCS_ACC_MIN);
  assign c_dec = cur_pct(16'(load_inertia_reg >> `RCS_INERT_SH), avail_run,
                         torque_utilization_reg, 7'h00);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stop_trig_reg <= 1'b0;
    else
      stop_trig_reg <= wr_do && ((aw_idx_reg == `RCS_IX_LG) ||
                       (aw_idx_reg == `RCS_IX_LSF) || (aw_idx_reg == `RCS_IX_TU));
  end

  // Trigger is one cycle late so the new load value is already stored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_current_pct_reg <= `RCS_RUN_DEF;
      stop_current_pct_reg <= `RCS_STOP_DEF;
      accel_current_pct_reg <= `RCS_ACC_DEF;
      decel_current_pct_reg <= `RCS_ACC_DEF;
      clamp_warning <= 1'b0;
    end
    else if (auto_on && motion_start)
    begin
      run_current_pct_reg <= c_run[6:0];
      stop_current_pct_reg <= c_stop[6:0];
      accel_current_pct_reg <= c_acc[6:0];
      decel_current_pct_reg <= c_dec[6:0];
      clamp_warning <= (alarm_message_verbosity_reg == `RCS_VERB_WARN) &&
                       (c_run[7] || c_stop[7] || c_acc[7] || c_dec[7]);
    end
    else if (auto_on && stop_trig_reg)
    begin
      stop_current_pct_reg <= c_stop[6:0];
      clamp_warning <= (alarm_message_verbosity_reg == `RCS_VERB_WARN) && c_stop[7];
    end
    else
    begin
      clamp_warning <= 1'b0;
      if (wr_do && aw_idx_reg == `RCS_IX_RUN)
        run_current_pct_reg <= wd[6:0];
      if (wr_do && aw_idx_reg == `RCS_IX_STOP)
        stop_current_pct_reg <= wd[6:0];
      if (wr_do && aw_idx_reg == `RCS_IX_ACC)
        accel_current_pct_reg <= wd[6:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase_current_pct <= `RCS_STOP_DEF;
    else if (motion_state_reg == rcs_pkg::MS_STOP)
      phase_current_pct <= stop_current_pct_reg;
    else if (eff_method == rcs_pkg::CM_BASIC || motion_state_reg == rcs_pkg::MS_CONST)
      phase_current_pct <= run_current_pct_reg;
    else if (auto_on && motion_state_reg == rcs_pkg::MS_DECEL)
      phase_current_pct <= decel_current_pct_reg;
    else
      phase_current_pct <= accel_current_pct_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prof_start_velocity <= 32'h0;
      prof_accel_time <= 32'h0;
      prof_decel_time <= 32'h0;
      auto_accel_rate <= 16'h0000;
    end
    else
    begin
      prof_start_velocity <= ramp_profile_select_reg ? 32'h0 : start_velocity_reg;
      prof_accel_time <= ramp_profile_select_reg ? 32'h0 : accel_time_reg;
      prof_decel_time <= ramp_profile_select_reg ? 32'h0 : decel_time_reg;
      auto_accel_rate <= !ramp_profile_select_reg ? 16'h0000 :
        16'((32'(avail_tq(nominal_supply_voltage_reg, vmag)) *
             32'(torque_utilization_reg)) / `RCS_PCT_MAX);
    end
  end

  // Measured supply comes from another domain, so two flops first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sup_s1_reg <= `RCS_VNOM_DEF;
      sup_s2_reg <= `RCS_VNOM_DEF;
      sup_s3_reg <= `RCS_VNOM_DEF;
      sup_q_reg <= `RCS_VNOM_DEF;
    end
    else
    begin
      sup_s1_reg <= supply_mv;
      sup_s2_reg <= sup_s1_reg;
      sup_s3_reg <= sup_s2_reg;
      // Word taken only when two samples agree, so a torn capture is never used
      if (sup_s2_reg == sup_s3_reg)
        sup_q_reg <= sup_s3_reg;
    end
  end
  assign warn_next = (20'(sup_q_reg) * `RCS_TOL_SCALE >
                      20'(nominal_supply_voltage_reg) * `RCS_TOL_HI) ||
                     (20'(sup_q_reg) * `RCS_TOL_SCALE <
                      20'(nominal_supply_voltage_reg) * `RCS_TOL_LO);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      supply_warning <= 1'b0;
    else
      supply_warning <= warn_next;
  end

  always_comb
  begin
    case (s_axi_araddr[7:2])
      `RCS_IX_RAMP: rmux = 32'(ramp_profile_select_reg);
      `RCS_IX_METH: rmux = 32'(current_method_select_reg);
      `RCS_IX_OPMODE: rmux = 32'(op_mode_reg);
      `RCS_IX_VNOM: rmux = 32'(nominal_supply_voltage_reg);
      `RCS_IX_TU: rmux = 32'(torque_utilization_reg);
      `RCS_IX_RUN: rmux = 32'(run_current_pct_reg);
      `RCS_IX_STOP: rmux = 32'(stop_current_pct_reg);
      `RCS_IX_ACC: rmux = 32'(accel_current_pct_reg);
      `RCS_IX_DEC: rmux = 32'(decel_current_pct_reg);
      `RCS_IX_LI: rmux = 32'(load_inertia_reg);
      `RCS_IX_LF: rmux = 32'(load_friction_reg);
      `RCS_IX_LG: rmux = 32'(load_gravity_reg);
      `RCS_IX_LSF: rmux = 32'(static_load_friction_reg);
      `RCS_IX_VS: rmux = start_velocity_reg;
      `RCS_IX_VR: rmux = running_velocity_reg;
      `RCS_IX_TA: rmux = accel_time_reg;
      `RCS_IX_TD: rmux = decel_time_reg;
      `RCS_IX_VERB: rmux = 32'(alarm_message_verbosity_reg);
      `RCS_IX_STAT: rmux = {27'h0, eff_method, motion_state_reg, supply_warning};
      default: rmux = 32'h0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RCS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rmux;
      s_axi_rresp <= (s_axi_araddr[7:2] > `RCS_IX_STAT) ? `RCS_RESP_DECERR : `RCS_RESP_OKAY;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  sequence seq_enter_decel;
    motion_state_reg != rcs_pkg::MS_DECEL ##1 motion_state_reg == rcs_pkg::MS_DECEL && auto_on;
  endsequence
  sequence seq_auto_write_cur;
    wr_go && current_method_select_reg == rcs_pkg::CM_AUTO &&
    (aw_idx_reg == `RCS_IX_RUN || aw_idx_reg == `RCS_IX_STOP);
  endsequence

  chk_ramp_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    motion_state_reg != rcs_pkg::MS_STOP |=> $stable(ramp_profile_select_reg))
    else $error("ramp profile changed while moving");
  chk_linear_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    !ramp_profile_select_reg && $stable(accel_time_reg)
    |=> prof_accel_time == $past(accel_time_reg))
    else $error("linear accel time not passed");
  chk_auto_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
    ramp_profile_select_reg |=> prof_start_velocity == 32'h0 && prof_decel_time == 32'h0)
    else $error("auto ramp used programmed profile");
  chk_supply_warn: assert property (@(posedge aclk) disable iff (!aresetn)
    $stable(sup_q_reg) && $stable(nominal_supply_voltage_reg) ##1 warn_next |=> supply_warning)
    else $error("supply deviation not flagged");
  chk_basic_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    eff_method == rcs_pkg::CM_BASIC && motion_state_reg == rcs_pkg::MS_STOP
    |=> phase_current_pct == $past(stop_current_pct_reg))
    else $error("basic stop current wrong");
  chk_manual_accel: assert property (@(posedge aclk) disable iff (!aresetn)
    eff_method == rcs_pkg::CM_MANUAL && motion_state_reg == rcs_pkg::MS_ACCEL
    |=> phase_current_pct == $past(accel_current_pct_reg))
    else $error("manual accel current wrong");
  chk_auto_decel: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_enter_decel |=> phase_current_pct == $past(decel_current_pct_reg))
    else $error("auto decel current not applied");
  chk_auto_reject: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_auto_write_cur |=> s_axi_bvalid && s_axi_bresp == `RCS_RESP_SLVERR)
    else $error("auto current write accepted");
  chk_run_held: assert property (@(posedge aclk) disable iff (!aresetn)
    current_method_select_reg == rcs_pkg::CM_AUTO && !motion_start
    |=> $stable(run_current_pct_reg))
    else $error("run current changed outside motion start");
  chk_clamp_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    alarm_message_verbosity_reg != `RCS_VERB_WARN |=> !clamp_warning)
    else $error("clamp warning at low verbosity");
  chk_method_range: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && aw_idx_reg == `RCS_IX_METH && wd > `RCS_METH_MAX
    |=> $stable(current_method_select_reg))
    else $error("illegal current method stored");
endmodule : rcs_selector

// *** testbench/rcs_power_stage.sv ***
// Supply side of the power stage seen by the selector
`timescale 1ns/1ps
module rcs_power_stage (
  input wire logic aclk,
  input wire logic [15:0] supply_set,
  output logic [15:0] supply_mv
);
  // Registered, so a step reaches the pins only after a clock edge
  always_ff @(posedge aclk)
    supply_mv <= supply_set;
endmodule : rcs_power_stage

// *** testbench/tb.sv ***
// Self-checking bench for the ramp and current selector
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic supply_warning, clamp_warning;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, prof_start_velocity, prof_accel_time, prof_decel_time;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, motion_state;
  logic signed [31:0] cmd_velocity;
  logic [15:0] supply_mv, supply_set, auto_accel_rate;
  logic [6:0] phase_current_pct;
  int num_errors, n_checks, n_clamp;
  // Clamp warning is a one-cycle pulse, so it is counted here
  always @(posedge aclk)
    n_clamp <= n_clamp + int'(clamp_warning);
  rcs_selector DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmd_velocity, .supply_mv, .phase_current_pct, .motion_state,
    .supply_warning, .clamp_warning, .prof_start_velocity, .prof_accel_time, .prof_decel_time,
    .auto_accel_rate);
  rcs_power_stage u_stage (.aclk, .supply_set, .supply_mv);
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic wr(input logic [5:0] ix, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= {ix, 2'h0};
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
    // One edge passes so bready is never lowered and raised in one step
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [5:0] ix, input logic [31:0] d, input logic [1:0] er);
    s_axi_araddr <= {ix, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK("rdata", d, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
    @(posedge aclk);
  endtask : rd
  // Steps the commanded velocity once per cycle, so the motion state sees a change each edge
  task automatic ramp(input logic signed [31:0] step, input int n);
    repeat (n)
    begin
      cmd_velocity <= cmd_velocity + step;
      @(posedge aclk);
    end
  endtask : ramp
  task automatic cur(input logic [6:0] c, input logic [1:0] s);
    `CHK("current", c, phase_current_pct)
    `CHK("state", s, motion_state)
  endtask : cur
  task automatic sup(input logic [15:0] v, input logic w);
    supply_set <= v;
    repeat (8) @(posedge aclk);
    `CHK("supply_warning", w, supply_warning)
  endtask : sup
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    test_done;
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0000F;
    cmd_velocity = 32'sh0;
    supply_set = 16'h5DC0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cur(7'h32, 2'h0);
    rd(6'h00, 32'h0, 2'h0);
    rd(6'h01, 32'h0, 2'h0);
    rd(6'h03, 32'h5DC0, 2'h0);
    rd(6'h04, 32'h32, 2'h0);
    rd(6'h07, 32'h64, 2'h0);
    rd(6'h0D, 32'h64, 2'h0);
    `CHK("accel_time", 32'h1F4, prof_accel_time)
    `CHK("accel_rate", 16'h0, auto_accel_rate)
    $display("test defaults done");
    ramp(32'sh1F4, 1);
    repeat (4) @(posedge aclk);
    cur(7'h64, 2'h2);
    wr(6'h00, 32'h1, 2'h2);
    wr(6'h07, 32'h1E, 2'h2);
    ramp(-32'sh1F4, 1);
    repeat (4) @(posedge aclk);
    cur(7'h32, 2'h0);
    wr(6'h00, 32'h2, 2'h2);
    wr(6'h00, 32'h1, 2'h0);
    repeat (3) @(posedge aclk);
    `CHK("start_vel", 32'h0, prof_start_velocity)
    `CHK("decel_time", 32'h0, prof_decel_time)
    wr(6'h00, 32'h0, 2'h0);
    $display("test ramp and basic done");
    wr(6'h01, 32'h1, 2'h0);
    wr(6'h07, 32'h1E, 2'h0);
    ramp(32'sh0A, 6);
    cur(7'h1E, 2'h1);
    ramp(-32'sh0A, 3);
    cur(7'h1E, 2'h3);
    wr(6'h02, 32'h1, 2'h0);
    ramp(32'sh0A, 6);
    cur(7'h64, 2'h1);
    wr(6'h02, 32'h0, 2'h0);
    ramp(-32'sh0A, 9);
    $display("test manual done");
    wr(6'h01, 32'h2, 2'h0);
    wr(6'h05, 32'h28, 2'h2);
    wr(6'h06, 32'h28, 2'h2);
    wr(6'h08, 32'h28, 2'h2);
    wr(6'h09, 32'h2EE0, 2'h0);
    wr(6'h09, 32'h2EE1, 2'h2);
    wr(6'h09, 32'h0, 2'h0);
    wr(6'h11, 32'h2, 2'h0);
    ramp(32'sh0A, 3);
    cur(7'h19, 2'h1);
    `CHK("clamp_count", 1, n_clamp)
    ramp(-32'sh0A, 3);
    cur(7'h00, 2'h3);
    rd(6'h06, 32'h0, 2'h0);
    wr(6'h01, 32'h3, 2'h2);
    rd(6'h13, 32'h0, 2'h3);
    wr(6'h01, 32'h0, 2'h0);
    $display("test auto done");
    sup(16'h6784, 1'b1);
    sup(16'h6720, 1'b0);
    sup(16'h545F, 1'b1);
    sup(16'h5460, 1'b0);
    $display("test supply done");
    test_done;
  end
endmodule : tb
